// ### aape_exec.sv
// Executor for accumulator add, add with carry, AND and in-page jump, with APB registers
//
// Behaviour
// [RL1] Add indirect-addressed data byte to accumulator
// [RL2] Add working register to accumulator
// [RL3] Add direct-addressed data byte to accumulator
// [RL4] Immediate add with carry updates carry
// [RL5] Immediate add with carry decodes from 00110100
// [RL6] Indirect add with carry updates carry
// [RL7] Register add with carry updates carry
// [RL8] Direct add with carry updates carry
// [RL9] Accumulator and carry hold full sum
// [RL10] Adds set flags; AND keeps them; parity tracks
// [RL11] Jump: counter plus two, low bits replaced
// [RL12] Jump target: opcode top bits, second byte
// [RL13] Program keeps jump targets within page
// [RL14] AND immediate byte into accumulator
// [RL15] AND works bit by bit
// [RL16] AND indirect-addressed byte into accumulator
// [RL17] AND working register into accumulator
// [RL18] AND direct-addressed byte into accumulator
// [RL19] Counter always advances past instruction bytes
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module aape_exec (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Status
	output logic busy
);
	aape_pkg::aape_state_rec_t r;        // Current state
	aape_pkg::aape_state_rec_t next_r;   // Next state
	logic [7:0] prog_mem [0:255];        // Program memory
	logic [7:0] data_mem [0:255];        // Internal data memory
	logic [7:0] cur_byte;                // Byte at the counter
	logic [7:0] reg_addr;                // Address of selected working register
	logic [7:0] reg_val;                 // Selected working register
	logic [7:0] ind_val;                 // Byte pointed to by working register
	logic [7:0] dir_val;                 // Byte at direct address
	logic [7:0] operand;                 // Chosen second operand
	aape_pkg::aape_src_t src;            // Operand source of latched opcode
	aape_pkg::aape_cls_t cls;            // Class of latched opcode
	aape_pkg::aape_cls_t fcls;           // Class of the byte being fetched
	aape_pkg::aape_alu_t alu;            // Unit outputs
	logic alu_cin;                       // Carry in to the unit
	logic acc_par;                       // Parity of accumulator
	logic wr_fire;                       // Bus write takes effect now
	logic acc_phase;                     // Access phase in progress
	logic addr_ok;                       // Address decodes
	logic [31:0] rd_mux;                 // Read data before capture

	////////////////////////////////////////////////////////////////////////////////
	// Class decode of an opcode byte
	function automatic aape_pkg::aape_cls_t class_of(input logic [7:0] o);
		aape_pkg::aape_cls_t c;
		c = aape_pkg::CLS_BAD;
		if (o == aape_pkg::OP_ADD_IMM || o == aape_pkg::OP_ADD_DIR ||
			o[7:1] == aape_pkg::OP_ADD_IND || o[7:3] == aape_pkg::OP_ADD_REG) begin
			c = aape_pkg::CLS_ADD;
		end else if (o == aape_pkg::OP_SWC_IMM || o == aape_pkg::OP_SWC_DIR || // [RL5]
			o[7:1] == aape_pkg::OP_SWC_IND || o[7:3] == aape_pkg::OP_SWC_REG) begin
			c = aape_pkg::CLS_SWC;
		end else if (o == aape_pkg::OP_AND_IMM || o == aape_pkg::OP_AND_DIR ||
			o[7:1] == aape_pkg::OP_AND_IND || o[7:3] == aape_pkg::OP_AND_REG) begin
			c = aape_pkg::CLS_AND;
		end else if (o[4:0] == aape_pkg::OP_JMP_LOW) begin
			c = aape_pkg::CLS_JMP;
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Operand source of an opcode byte
	function automatic aape_pkg::aape_src_t source_of(input logic [7:0] o);
		aape_pkg::aape_src_t s;
		s = aape_pkg::SRC_IMM;
		if (o[3]) begin
			s = aape_pkg::SRC_REG;
		end else if (o[2:1] == 2'b11) begin
			s = aape_pkg::SRC_IND;
		end else if (o[0]) begin
			s = aape_pkg::SRC_DIR;
		end
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Shared arithmetic and AND unit
	aape_alu #(
		.W(8)
	) u_alu (
		.a(r.acc),
		.b(operand),
		.cin(alu_cin),
		.is_and(cls == aape_pkg::CLS_AND),
		.res(alu.res),
		.cy(alu.cy),
		.aux(alu.aux),
		.ovf(alu.ovf)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Memory reads and operand selection
	always_comb begin
		cur_byte = prog_mem[r.pc[7:0]];
		cls = class_of(r.op);
		fcls = class_of(cur_byte);
		src = source_of(r.op);
		// Working registers live in the bank chosen by the status word
		reg_addr = {3'b000, r.flags[aape_pkg::FLG_RS1], r.flags[aape_pkg::FLG_RS0], 3'b000};
		if (src == aape_pkg::SRC_IND) begin
			reg_addr[2:0] = {2'b00, r.op[0]};  // [RL1] [RL6] [RL16]
		end else begin
			reg_addr[2:0] = r.op[2:0];  // [RL2] [RL7] [RL17]
		end
		reg_val = data_mem[reg_addr];
		ind_val = data_mem[reg_val];
		dir_val = data_mem[r.opnd];  // [RL3] [RL8] [RL18]
		case (src)
			aape_pkg::SRC_IMM: operand = r.opnd;  // [RL4] [RL14]
			aape_pkg::SRC_DIR: operand = dir_val;
			aape_pkg::SRC_REG: operand = reg_val;
			aape_pkg::SRC_IND: operand = ind_val;
			default: operand = r.opnd;
		endcase
		// Carry enters only the add-with-carry forms
		alu_cin = (cls == aape_pkg::CLS_SWC) ? r.flags[aape_pkg::FLG_CY] : 1'b0;  // [RL9]
		acc_par = ^r.acc;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode and read data selection
	always_comb begin
		acc_phase = psel && penable;
		wr_fire = acc_phase && r.ack && pwrite;
		addr_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			aape_pkg::OFS_CTRL: rd_mux[aape_pkg::CTRL_RUN] = r.run;
			aape_pkg::OFS_STATUS: begin
				rd_mux[aape_pkg::STAT_BUSY] = (r.st != aape_pkg::ST_IDLE);
				rd_mux[aape_pkg::STAT_BAD_OP] = r.bad_op;
			end
			aape_pkg::OFS_ACC: rd_mux[7:0] = r.acc;
			// Parity always reflects the present accumulator
			aape_pkg::OFS_FLAGS: rd_mux[7:0] = {r.flags[7:1], acc_par};  // [RL10]
			aape_pkg::OFS_PC: rd_mux[15:0] = r.pc;
			aape_pkg::OFS_PM_ADDR: rd_mux[7:0] = r.pm_ptr;
			aape_pkg::OFS_PM_DATA: rd_mux[7:0] = prog_mem[r.pm_ptr];
			aape_pkg::OFS_DM_ADDR: rd_mux[7:0] = r.dm_ptr;
			aape_pkg::OFS_DM_DATA: rd_mux[7:0] = data_mem[r.dm_ptr];
			default: addr_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: bus registers and instruction sequencer
	always_comb begin
		next_r = r;
		// Bus answers one cycle into the access phase
		next_r.ack = acc_phase && !r.ack;
		if (acc_phase && !r.ack) begin
			next_r.rdata = pwrite ? 32'h0000_0000 : rd_mux;
		end
		// Single step is consumed when a fetch starts
		if (r.st == aape_pkg::ST_IDLE && r.step) begin
			next_r.step = 1'b0;
		end

		// Sequencer
		case (r.st)
			aape_pkg::ST_IDLE: begin
				if (r.run || r.step) begin
					next_r.st = aape_pkg::ST_FETCH;
				end
			end
			aape_pkg::ST_FETCH: begin
				next_r.op = cur_byte;
				next_r.pc = r.pc + 16'h0001;  // [RL19]
				if (fcls == aape_pkg::CLS_JMP || (fcls != aape_pkg::CLS_BAD &&
					source_of(cur_byte) inside {aape_pkg::SRC_IMM, aape_pkg::SRC_DIR})) begin
					next_r.st = aape_pkg::ST_OPND;
				end else begin
					next_r.st = aape_pkg::ST_EXEC;
				end
			end
			aape_pkg::ST_OPND: begin
				// Second byte; counter now past both bytes
				next_r.opnd = cur_byte;
				next_r.pc = r.pc + 16'h0001;  // [RL11] [RL19]
				next_r.st = (cls == aape_pkg::CLS_JMP) ? aape_pkg::ST_JUMP : aape_pkg::ST_EXEC;
			end
			aape_pkg::ST_EXEC: begin
				case (cls)
					aape_pkg::CLS_ADD, aape_pkg::CLS_SWC: begin
						next_r.acc = alu.res;  // [RL1] [RL2] [RL3] [RL4] [RL6] [RL7] [RL8]
						next_r.flags[aape_pkg::FLG_CY] = alu.cy;  // [RL9] [RL10]
						next_r.flags[aape_pkg::FLG_AUX] = alu.aux;  // [RL10]
						next_r.flags[aape_pkg::FLG_OVF] = alu.ovf;  // [RL10]
					end
					aape_pkg::CLS_AND: begin
						// Flags other than parity stay as they were
						next_r.acc = alu.res;  // [RL10] [RL14] [RL16] [RL17] [RL18]
					end
					default: begin
						// Unsupported opcode: one byte skipped, flagged
						next_r.bad_op = 1'b1;
					end
				endcase
				next_r.st = aape_pkg::ST_IDLE;
			end
			aape_pkg::ST_JUMP: begin
				// Upper five counter bits kept; program keeps target in page
				next_r.pc = {r.pc[15:11], r.op[7:5], r.opnd};  // [RL11] [RL12] [RL13]
				next_r.st = aape_pkg::ST_IDLE;
			end
			default: next_r.st = aape_pkg::ST_IDLE;
		endcase

		// Register writes, ignored for core state while busy
		if (wr_fire) begin
			case (paddr)
				aape_pkg::OFS_CTRL: begin
					next_r.run = pwdata[aape_pkg::CTRL_RUN];
					if (pwdata[aape_pkg::CTRL_STEP]) begin
						next_r.step = 1'b1;
					end
				end
				aape_pkg::OFS_STATUS: begin
					// Write one clears; a new bad opcode in the same cycle wins
					if (pwdata[aape_pkg::STAT_BAD_OP] && !(r.st == aape_pkg::ST_EXEC &&
						cls == aape_pkg::CLS_BAD)) begin
						next_r.bad_op = 1'b0;
					end
				end
				aape_pkg::OFS_ACC: begin
					if (r.st == aape_pkg::ST_IDLE) begin
						next_r.acc = pwdata[7:0];
					end
				end
				aape_pkg::OFS_FLAGS: begin
					if (r.st == aape_pkg::ST_IDLE) begin
						next_r.flags = pwdata[7:0];
					end
				end
				aape_pkg::OFS_PC: begin
					if (r.st == aape_pkg::ST_IDLE) begin
						next_r.pc = pwdata[15:0];
					end
				end
				aape_pkg::OFS_PM_ADDR: next_r.pm_ptr = pwdata[7:0];
				aape_pkg::OFS_PM_DATA: next_r.pm_ptr = r.pm_ptr + 8'h01;
				aape_pkg::OFS_DM_ADDR: next_r.dm_ptr = pwdata[7:0];
				aape_pkg::OFS_DM_DATA: next_r.dm_ptr = r.dm_ptr + 8'h01;
				default: next_r.run = r.run;
			endcase
		end
		// Parity kept current in the stored word
		next_r.flags[aape_pkg::FLG_PAR] = ^next_r.acc;  // [RL10]
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.st <= aape_pkg::ST_IDLE;
			r.pc <= aape_pkg::RST_PC;
			r.acc <= aape_pkg::RST_ACC;
			r.flags <= aape_pkg::RST_FLAGS;
			r.op <= 8'h00;
			r.opnd <= 8'h00;
			r.run <= 1'b0;
			r.step <= 1'b0;
			r.bad_op <= 1'b0;
			r.pm_ptr <= 8'h00;
			r.dm_ptr <= 8'h00;
			r.rdata <= 32'h0000_0000;
			r.ack <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Memory loads from the bus data ports
	always_ff @(posedge pclk) begin
		if (wr_fire && paddr == aape_pkg::OFS_PM_DATA) begin
			prog_mem[r.pm_ptr] <= pwdata[7:0];
		end
		if (wr_fire && paddr == aape_pkg::OFS_DM_DATA) begin
			data_mem[r.dm_ptr] <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		prdata = r.rdata;
		pready = r.ack;
		pslverr = r.ack && !addr_ok;
		busy = (r.st != aape_pkg::ST_IDLE);
	end
endmodule // aape_exec

// ### aape_pkg.sv
// Package: register map, field layout, opcodes, states and state record of the executor
package aape_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL = 8'h00;     // Run level, single step
	localparam logic [7:0] OFS_STATUS = 8'h04;   // Busy, bad opcode flag
	localparam logic [7:0] OFS_ACC = 8'h08;      // Accumulator
	localparam logic [7:0] OFS_FLAGS = 8'h0C;    // program_status_word
	localparam logic [7:0] OFS_PC = 8'h10;       // Program counter
	localparam logic [7:0] OFS_PM_ADDR = 8'h14;  // Program memory pointer
	localparam logic [7:0] OFS_PM_DATA = 8'h18;  // Program memory data port
	localparam logic [7:0] OFS_DM_ADDR = 8'h1C;  // Data memory pointer
	localparam logic [7:0] OFS_DM_DATA = 8'h20;  // Data memory data port

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTRL_RUN = 0;       // Free running while set
	localparam int CTRL_STEP = 1;      // Write one: execute one instruction
	localparam int STAT_BUSY = 0;      // An instruction is in flight
	localparam int STAT_BAD_OP = 1;    // Sticky: unsupported opcode seen
	localparam int FLG_CY = 7;         // Carry flag
	localparam int FLG_AUX = 6;        // aux_carry
	localparam int FLG_RS1 = 4;        // Bank select high
	localparam int FLG_RS0 = 3;        // Bank select low
	localparam int FLG_OVF = 2;        // signed_excess_flag
	localparam int FLG_PAR = 0;        // Parity of accumulator

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [15:0] RST_PC = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Opcode patterns
	localparam logic [7:0] OP_ADD_IMM = 8'h24;      // 00100100
	localparam logic [7:0] OP_ADD_DIR = 8'h25;      // 00100101
	localparam logic [6:0] OP_ADD_IND = 7'h13;      // 0010011r
	localparam logic [4:0] OP_ADD_REG = 5'h05;      // 00101rrr
	localparam logic [7:0] OP_SWC_IMM = 8'h34;      // 00110100
	localparam logic [7:0] OP_SWC_DIR = 8'h35;      // 00110101
	localparam logic [6:0] OP_SWC_IND = 7'h1B;      // 0011011r
	localparam logic [4:0] OP_SWC_REG = 5'h07;      // 00111rrr
	localparam logic [7:0] OP_AND_IMM = 8'h54;      // 01010100
	localparam logic [7:0] OP_AND_DIR = 8'h55;      // 01010101
	localparam logic [6:0] OP_AND_IND = 7'h2B;      // 0101011r
	localparam logic [4:0] OP_AND_REG = 5'h0B;      // 01011rrr
	localparam logic [4:0] OP_JMP_LOW = 5'h01;      // aaa00001

	// Operand sources
	typedef enum logic [1:0] {
		SRC_IMM = 2'b00,
		SRC_DIR = 2'b01,
		SRC_REG = 2'b10,
		SRC_IND = 2'b11
	} aape_src_t;

	// Instruction classes
	typedef enum logic [2:0] {
		CLS_ADD = 3'b000,
		CLS_SWC = 3'b001,
		CLS_AND = 3'b010,
		CLS_JMP = 3'b011,
		CLS_BAD = 3'b100
	} aape_cls_t;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_OPND = 3'b010,
		ST_EXEC = 3'b011,
		ST_JUMP = 3'b100
	} aape_state_t;

	// State of the executor apart from its program and data memories
	typedef struct packed {
		aape_state_t st;      // Sequencer state
		logic [15:0] pc;      // Program counter
		logic [7:0] acc;      // Accumulator
		logic [7:0] flags;    // program_status_word, parity bit recomputed
		logic [7:0] op;       // Latched opcode
		logic [7:0] opnd;     // Latched second byte
		logic run;            // Free running
		logic step;           // One step pending
		logic bad_op;         // Sticky bad opcode
		logic [7:0] pm_ptr;   // Program memory pointer
		logic [7:0] dm_ptr;   // Data memory pointer
		logic [31:0] rdata;   // Registered read data
		logic ack;            // Access phase answered
	} aape_state_rec_t;

	// Arithmetic unit results
	typedef struct packed {
		logic [7:0] res;      // Result byte
		logic cy;             // Carry out
		logic aux;            // Carry out of low nibble
		logic ovf;            // Signed overflow
	} aape_alu_t;

endpackage

// ### aape_alu.sv
// Adder and bitwise AND unit with flag outputs
`timescale 1ns/1ps
module aape_alu #(
	parameter int W = 8
) (
	// Operands
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic cin,
	input wire logic is_and,
	// Results
	output logic [W-1:0] res,
	output logic cy,
	output logic aux,
	output logic ovf
);
	logic [W:0] sum_full;     // Complete sum including carry out
	logic [4:0] sum_low;      // Low nibble sum for aux carry
	logic [W-1:0] sum_lo7;    // Sum of lower W-1 bits for carry into msb

	////////////////////////////////////////////////////////////////////////////////
	// Sums of all three inputs, carry in counted as 0 or 1
	always_comb begin
		sum_full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};  // [RL9]
		sum_low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		sum_lo7 = {1'b0, a[W-2:0]} + {1'b0, b[W-2:0]} + {{(W-1){1'b0}}, cin};
		if (is_and) begin
			res = a & b;  // [RL15]
		end else begin
			res = sum_full[W-1:0];
		end
		cy = sum_full[W];
		aux = sum_low[4];
		ovf = sum_full[W] ^ sum_lo7[W-1];
	end
endmodule // aape_alu

// ### aape_exec_checker.sv
// Checker: bus timing, error answer and busy length of the executor
`timescale 1ns/1ps
module aape_exec_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// Bus answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Status
	input wire logic busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	logic mapped; // Aligned address inside the map
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h20);

	// Setup cycle followed by first access cycle
	sequence s_enter;
		psel && !penable ##1 psel && penable;
	endsequence
	// Exactly one wait state
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	// Instruction in flight: at least two cycles, at most three
	sequence s_instr;
		busy[*2] ##[1:2] !busy;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	chk_wait_state: assert property (s_enter |-> s_one_wait)
		else $error("ready not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	chk_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_err_mapped: assert property (pready && mapped |-> !pslverr)
		else $error("mapped access refused");
	chk_upper_zero: assert property (pready && mapped |-> prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	chk_rdata_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pready))
		else $error("read data changed outside capture");
	chk_busy_status: assert property (pready && !pwrite && paddr == aape_pkg::OFS_STATUS
		|-> prdata[0] == $past(busy))
		else $error("status busy bit wrong");
	chk_instr_len: assert property ($rose(busy) |-> s_instr)
		else $error("instruction length wrong");
endmodule // aape_exec_checker

bind aape_exec aape_exec_checker i_aape_exec_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

// ### aape_mem_model.sv
// Partner model: program image and data memory image fed to the executor
`timescale 1ns/1ps
module aape_mem_model;
	logic [7:0] pm [18]; // Program bytes from address 0
	logic [7:0] dm_a [10]; // Data memory addresses
	logic [7:0] dm_v [10]; // Data memory contents
	// One instruction of each form except immediate add, then a jump that stays in its page
	initial begin
		pm = '{8'h27, 8'h2E, 8'h25, 8'h32, 8'h34, 8'hAF, 8'h36, 8'h3F, 8'h35, 8'h25,
			8'h54, 8'h08, 8'h57, 8'h5C, 8'h55, 8'h37, 8'hE1, 8'h0F};
		// Working registers of bank 0, then operand bytes
		dm_a = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h07, 8'h1C, 8'h32, 8'h69, 8'h25, 8'h37};
		dm_v = '{8'h69, 8'h1C, 8'h80, 8'h85, 8'h0A, 8'hC3, 8'h53, 8'h18, 8'h07, 8'hF0};
	end
endmodule // aape_mem_model

// ### aape_exec_bench.sv
// Testbench: loads a program over the bus and checks each instruction result
`timescale 1ns/1ps
module aape_exec_bench;
	logic pclk; // Clock
	logic presetn; // Reset, active low
	logic psel, penable, pwrite; // Bus control
	logic [7:0] paddr; // Bus address
	logic [31:0] pwdata, prdata; // Bus data
	logic pready, pslverr, busy; // Answers
	int err_total, n_tests, i; // Counters
	logic [31:0] rd; // Last read data
	logic err_seen; // Last error answer
	logic [15:0] pc_exp; // Expected counter
	logic [31:0] row; // Current table row
	// Rows: acc in, acc out, flags in {ov, aux, cy}, flags out {ov, aux, cy}, length
	logic [31:0] tv [11] = '{
		32'h25E8_6001,
		32'h76FB_6001,
		32'h4093_6402,
		32'h7121_7302,
		32'hE800_6301,
		32'h303B_7001,
		32'hAEB6_7202,
		32'h7700_7702,
		32'h3F03_6601,
		32'h9980_7701,
		32'h7770_6602};

	aape_exec i_aape_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy));
	aape_mem_model i_aape_mem_model ();

	////////////////////////////////////////////////////////////////////////////////
	// Clock of 10 ns
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Compare and count
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One bus transfer, waits for ready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			err_total++;
			$display("mismatch pready expected 1 seen %b", pready);
			results();
		end
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Wait for busy to reach a level under a bound
	task automatic wait_busy(input logic lvl);
		int k;
		for (k = 0; k < 20 && busy !== lvl; k++) begin
			@(posedge pclk);
		end
		if (busy !== lvl) begin
			err_total++;
			$display("mismatch busy expected %b seen %b", lvl, busy);
			results();
		end
	endtask

	// Execute a single instruction
	task automatic run_step();
		apb(1'b1, aape_pkg::OFS_CTRL, 32'h0000_0002);
		wait_busy(1'b1);
		wait_busy(1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		err_total = 0;
		n_tests = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values and refused address
		apb(1'b0, aape_pkg::OFS_PC, 32'h0);
		check("pc reset", 32'h0, rd);
		apb(1'b0, aape_pkg::OFS_STATUS, 32'h0);
		check("status reset", 32'h0, rd);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped error", 32'h1, {31'h0, err_seen});
		check("unmapped data", 32'h0, rd);
		$display("test reset done");
		// Load program and data memory
		apb(1'b1, aape_pkg::OFS_PM_ADDR, 32'h0);
		for (i = 0; i < 18; i++) begin
			apb(1'b1, aape_pkg::OFS_PM_DATA, {24'h0, i_aape_mem_model.pm[i]});
		end
		for (i = 0; i < 10; i++) begin
			apb(1'b1, aape_pkg::OFS_DM_ADDR, {24'h0, i_aape_mem_model.dm_a[i]});
			apb(1'b1, aape_pkg::OFS_DM_DATA, {24'h0, i_aape_mem_model.dm_v[i]});
		end
		// Each instruction form except immediate add in turn
		pc_exp = 16'h0000;
		for (i = 0; i < 11; i++) begin
			row = tv[i];
			apb(1'b1, aape_pkg::OFS_ACC, {24'h0, row[31:24]});
			apb(1'b1, aape_pkg::OFS_FLAGS, {24'h0, row[12], row[13], 3'h0, row[14], 2'h0});
			run_step();
			pc_exp = pc_exp + {14'h0, row[1:0]};
			apb(1'b0, aape_pkg::OFS_ACC, 32'h0);
			check("acc", {24'h0, row[23:16]}, rd);
			apb(1'b0, aape_pkg::OFS_FLAGS, 32'h0);
			check("carry", {31'h0, row[8]}, {31'h0, rd[7]});
			check("aux carry", {31'h0, row[9]}, {31'h0, rd[6]});
			check("overflow", {31'h0, row[10]}, {31'h0, rd[2]});
			check("parity", {31'h0, ^row[23:16]}, {31'h0, rd[0]});
			apb(1'b0, aape_pkg::OFS_PC, 32'h0);
			check("pc", {16'h0, pc_exp}, rd);
			$display("test %0d done", i);
		end
		// Jump from a high page keeps the upper counter bits
		apb(1'b1, aape_pkg::OFS_PC, 32'h0000_E810);
		run_step();
		apb(1'b0, aape_pkg::OFS_PC, 32'h0);
		check("jump pc", 32'h0000_EF0F, rd);
		$display("test jump done");
		// Free running round a bad opcode and a jump back, then stopped
		apb(1'b1, aape_pkg::OFS_PM_ADDR, 32'h12);
		apb(1'b1, aape_pkg::OFS_PM_DATA, 32'h00);
		apb(1'b1, aape_pkg::OFS_PM_DATA, 32'h01);
		apb(1'b1, aape_pkg::OFS_PM_DATA, 32'h12);
		apb(1'b1, aape_pkg::OFS_PM_ADDR, 32'h12);
		apb(1'b0, aape_pkg::OFS_PM_DATA, 32'h0);
		check("code read", 32'h0, rd);
		apb(1'b1, aape_pkg::OFS_PC, 32'h12);
		apb(1'b1, aape_pkg::OFS_CTRL, 32'h1);
		repeat (30) @(posedge pclk);
		apb(1'b1, aape_pkg::OFS_CTRL, 32'h0);
		wait_busy(1'b0);
		apb(1'b0, aape_pkg::OFS_STATUS, 32'h0);
		check("bad opcode", 32'h2, rd);
		apb(1'b0, aape_pkg::OFS_PC, 32'h0);
		check("loop pc", 32'h1, {31'h0, rd == 32'h12 || rd == 32'h13});
		apb(1'b1, aape_pkg::OFS_STATUS, 32'h2);
		apb(1'b0, aape_pkg::OFS_STATUS, 32'h0);
		check("bad opcode clear", 32'h0, rd);
		$display("test run done");
		results();
	end
endmodule // aape_exec_bench
